// *** core/fes_seq_cfg.svh ***
// Constants for the fetch and execute sequencer: offsets, fields, resets.
`ifndef FES_SEQ_CFG_SVH
`define FES_SEQ_CFG_SVH

// Register word offsets on the Avalon slave.
`define FES_OFF_CTRL 3'h0
`define FES_OFF_PORT_OUT 3'h1
`define FES_OFF_PORT_CFG 3'h2
`define FES_OFF_PORT_IN 3'h3
`define FES_OFF_STATUS 3'h4
`define FES_OFF_PMEM_ADDR 3'h5
`define FES_OFF_PMEM_DATA 3'h6

// Field positions.
`define FES_CTRL_MASTER_CLEAR_PIN_BIT 0
`define FES_PORT_IN_CHG_BIT 8
`define FES_STAT_VALID_BIT 31

// Reset values.
`define FES_CTRL_RST 3'h1
`define FES_PORT_OUT_RST 6'h00
`define FES_PORT_CFG_RST 6'h00
`define FES_CAL_RST 12'h000

// Pin two function select codes.
`define FES_P2_GPIO 2'h0
`define FES_P2_TIMER 2'h1
`define FES_P2_COMP 2'h2
`define FES_P2_QUARTER 2'h3

`endif

// *** core/fes_seq_pkg.sv ***
// Types shared by the fetch and execute sequencer files.
package fes_seq_pkg;
    // One-hot phase of the instruction cycle.
    typedef enum logic [3:0] {
        FES_PH_ONE = 4'b0001,
        FES_PH_TWO = 4'b0010,
        FES_PH_THREE = 4'b0100,
        FES_PH_FOUR = 4'b1000
    } fes_phase_t;
endpackage

// *** core/fes_pmem.sv ***
// Program word memory with one write port and one registered read port.
module fes_pmem import fes_seq_pkg::*; #(
    parameter int DW = 12,
    parameter int AW = 8
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic re_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    // Storage array; flash contents are not cleared by reset.
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Write port.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // Read port; the word holds until the next read.
    always_ff @(posedge clk_i) begin
        if (re_i) begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule

// *** core/fes_seq.sv ***
// Top of the fetch and execute sequencer with its register slave.
//
// Chosen here: the address map and the Avalon-MM slave port.
`include "fes_seq_cfg.svh"

module fes_seq import fes_seq_pkg::*; #(
    parameter int PC_W = 9,
    parameter int IMPL_W = 8,
    parameter int IW = 12,
    parameter int FA_W = 5,
    parameter logic [11:0] CAL_VALUE = `FES_CAL_RST
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [2:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic jump_i,
    input wire logic [PC_W-1:0] jump_target_i,
    input wire logic dest_write_i,
    input wire logic [7:0] result_i,
    input wire logic [7:0] dmem_rdata_i,
    output logic [IW-1:0] exec_instr_o,
    output logic exec_valid_o,
    output logic [7:0] operand_o,
    output logic [3:0] phase_o,
    output logic dmem_rd_o,
    output logic dmem_wr_o,
    output logic [FA_W-1:0] dmem_addr_o,
    output logic [7:0] dmem_wdata_o,
    input wire logic [2:0] port_pin_in_i,
    output logic [2:0] port_pin_out_o,
    output logic [2:0] port_pin_oe_o,
    input wire logic port_pin_three_i,
    output logic [3:0] pull_up_en_o,
    input wire logic comparator_output_i,
    output logic timer_clock_input_o,
    output logic quarter_osc_output_o,
    output logic wake_o
);
    // Phase sequencer state.
    fes_phase_t phase_reg;
    // Program counter and address of the word being fetched.
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] fetch_addr_reg;
    // Prefetched word and whether it may execute.
    logic [IW-1:0] hold_reg;
    logic hold_valid_reg;
    // Instruction in execution and its validity.
    logic [IW-1:0] ir_reg;
    logic ir_valid_reg;
    // Data memory strobes, address and write data.
    logic dmem_rd_reg;
    logic dmem_wr_reg;
    logic [FA_W-1:0] dmem_addr_reg;
    logic [7:0] dmem_wdata_reg;
    logic [7:0] operand_reg;
    logic quarter_reg;
    // Software registers.
    logic [2:0] ctrl_reg;
    logic [5:0] port_out_reg;
    logic [5:0] port_cfg_reg;
    logic [PC_W-1:0] pmem_addr_reg;
    logic [31:0] pmem_addr_next;
    logic chg_flag_reg;
    logic [3:0] pin_last_reg;
    // Pin outputs.
    logic [2:0] pin_out_reg;
    logic [2:0] pin_oe_reg;
    logic [3:0] pull_reg;
    logic tclk_reg;
    logic wake_reg;
    // Bus slave state.
    logic wait_reg;
    logic [31:0] rdata_reg;
    // Memory read data.
    logic [IW-1:0] pmem_rdata;
    logic pmem_we;
    // Internal reset for the pipeline, including master clear.
    logic core_rst;
    logic [3:0] pins_now;
    logic [3:0] chg_now;
    logic bus_wr;
    logic top_word;

    // Folds an address into the implemented part of program memory.
    function automatic logic [IMPL_W-1:0] fold(input logic [PC_W-1:0] a);
        fold = a[IMPL_W-1:0];
    endfunction

    // Merges write data into an old value under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        merge = r;
    endfunction

    // Master clear pulls the core into reset while the pin is low.
    assign core_rst = reset_i |
        (ctrl_reg[`FES_CTRL_MASTER_CLEAR_PIN_BIT] & ~port_pin_three_i);
    assign pins_now = {port_pin_three_i, port_pin_in_i};
    // Pin change on the wake-enabled pins zero, one and three.
    assign chg_now = (pins_now ^ pin_last_reg) &
        {port_cfg_reg[5], 1'b0, port_cfg_reg[4:3]};
    // A bus write completes at the edge where waitrequest is low.
    assign bus_wr = avs_write_i & ~wait_reg;
    // The top implemented word is the calibration word.
    assign top_word = &fold(pmem_addr_reg);
    // Program writes that would hit the calibration word are dropped.
    assign pmem_we = bus_wr & (avs_address_i == `FES_OFF_PMEM_DATA) &
        (|avs_byteenable_i[1:0]) & ~top_word;
    // Address register value after a byte-masked write.
    assign pmem_addr_next = merge({{(32-PC_W){1'b0}}, pmem_addr_reg},
        avs_writedata_i, avs_byteenable_i);

    // Program word storage.
    fes_pmem #(
        .DW(IW),
        .AW(IMPL_W)
    ) u_pmem (
        .clk_i(clk_i),
        .we_i(pmem_we),
        .waddr_i(fold(pmem_addr_reg)),
        .wdata_i(avs_writedata_i[IW-1:0]),
        .re_i(phase_reg == FES_PH_TWO),
        .raddr_i(fold(fetch_addr_reg)),
        .rdata_o(pmem_rdata)
    );

    // Phase ring: four clocks make one instruction cycle.
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            phase_reg <= FES_PH_ONE;
        end else begin
            case (phase_reg)
                FES_PH_ONE: phase_reg <= FES_PH_TWO;
                FES_PH_TWO: phase_reg <= FES_PH_THREE;
                FES_PH_THREE: phase_reg <= FES_PH_FOUR;
                default: phase_reg <= FES_PH_ONE;
            endcase
        end
    end

    // Quarter clock is high through phases three and four.
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            quarter_reg <= 1'b0;
        end else begin
            quarter_reg <= (phase_reg == FES_PH_TWO) ||
                (phase_reg == FES_PH_THREE);
        end
    end

    // Program counter: advance at phase one, reload on a jump.
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            pc_reg <= '0;
            fetch_addr_reg <= '0;
        end else if (phase_reg == FES_PH_ONE) begin
            // The counter wraps on its own width.
            fetch_addr_reg <= pc_reg;
            pc_reg <= pc_reg + 1'b1;
        end else if (phase_reg == FES_PH_FOUR && ir_valid_reg &&
                     jump_i) begin
            pc_reg <= jump_target_i;
        end
    end

    // Prefetch holding register, captured at phase four.
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            hold_reg <= '0;
            hold_valid_reg <= 1'b0;
        end else if (phase_reg == FES_PH_FOUR) begin
            // The calibration word is served from its own constant.
            hold_reg <= (&fold(fetch_addr_reg)) ? CAL_VALUE[IW-1:0]
                                                : pmem_rdata;
            // A jump in execution discards the word just fetched.
            hold_valid_reg <= ~(ir_valid_reg & jump_i);
        end
    end

    // Instruction register loads the prefetched word at phase one.
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            ir_reg <= '0;
            ir_valid_reg <= 1'b0;
        end else if (phase_reg == FES_PH_ONE) begin
            ir_reg <= hold_reg;
            ir_valid_reg <= hold_valid_reg;
        end
    end

    // Data memory read strobe stands through phase two.
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            dmem_rd_reg <= 1'b0;
            dmem_addr_reg <= '0;
        end else begin
            dmem_rd_reg <= (phase_reg == FES_PH_ONE) &
                hold_valid_reg;
            if (phase_reg == FES_PH_ONE) begin
                dmem_addr_reg <= hold_reg[FA_W-1:0];
            end
        end
    end

    // Operand is taken at the end of phase two.
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            operand_reg <= 8'h00;
        end else if (phase_reg == FES_PH_TWO && ir_valid_reg) begin
            operand_reg <= dmem_rdata_i;
        end
    end

    // Result write strobe stands through phase four.
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            dmem_wr_reg <= 1'b0;
            dmem_wdata_reg <= 8'h00;
        end else begin
            dmem_wr_reg <= (phase_reg == FES_PH_THREE) & ir_valid_reg &
                dest_write_i;
            if (phase_reg == FES_PH_THREE) begin
                dmem_wdata_reg <= result_i;
            end
        end
    end

    // Control register and program address, written by software.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_reg <= `FES_CTRL_RST;
            port_out_reg <= `FES_PORT_OUT_RST;
            port_cfg_reg <= `FES_PORT_CFG_RST;
            pmem_addr_reg <= '0;
        end else if (bus_wr && avs_byteenable_i[0]) begin
            if (avs_address_i == `FES_OFF_CTRL) begin
                ctrl_reg <= avs_writedata_i[2:0];
            end else if (avs_address_i == `FES_OFF_PORT_OUT) begin
                port_out_reg <= avs_writedata_i[5:0];
            end else if (avs_address_i == `FES_OFF_PORT_CFG) begin
                port_cfg_reg <= avs_writedata_i[5:0];
            end else if (avs_address_i == `FES_OFF_PMEM_ADDR) begin
                pmem_addr_reg <= pmem_addr_next[PC_W-1:0];
            end
        end else if (bus_wr && avs_address_i == `FES_OFF_PMEM_ADDR) begin
            pmem_addr_reg <= pmem_addr_next[PC_W-1:0];
        end
    end

    // Pin change flag: set wins over a write-one clear.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_last_reg <= 4'h0;
            chg_flag_reg <= 1'b0;
        end else begin
            pin_last_reg <= pins_now;
            if (|chg_now) begin
                chg_flag_reg <= 1'b1;
            end else if (bus_wr && avs_address_i == `FES_OFF_PORT_IN &&
                         avs_byteenable_i[1] &&
                         avs_writedata_i[`FES_PORT_IN_CHG_BIT]) begin
                chg_flag_reg <= 1'b0;
            end
        end
    end

    // Pin drivers, pull-ups and alternate functions.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_out_reg <= 3'h0;
            pin_oe_reg <= 3'h0;
            pull_reg <= 4'h0;
            tclk_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            pin_out_reg[1:0] <= port_out_reg[1:0];
            pin_oe_reg[1:0] <= port_out_reg[4:3];
            // Pull-ups on pins zero, one and three; master clear forces.
            pull_reg <= {port_cfg_reg[2] | ctrl_reg[`FES_CTRL_MASTER_CLEAR_PIN_BIT],
                         1'b0, port_cfg_reg[1:0]};
            wake_reg <= chg_flag_reg;
            tclk_reg <= 1'b0;
            // Pin two alternate function selection.
            case (ctrl_reg[2:1])
                `FES_P2_TIMER: begin
                    pin_out_reg[2] <= 1'b0;
                    pin_oe_reg[2] <= 1'b0;
                    tclk_reg <= port_pin_in_i[2];
                end
                `FES_P2_COMP: begin
                    pin_out_reg[2] <= comparator_output_i;
                    pin_oe_reg[2] <= 1'b1;
                end
                `FES_P2_QUARTER: begin
                    pin_out_reg[2] <= quarter_reg;
                    pin_oe_reg[2] <= 1'b1;
                end
                default: begin
                    pin_out_reg[2] <= port_out_reg[2];
                    pin_oe_reg[2] <= port_out_reg[5];
                end
            endcase
        end
    end

    // Avalon slave: one wait cycle, read data registered.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else if (wait_reg && (avs_read_i || avs_write_i)) begin
            wait_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            if (avs_address_i == `FES_OFF_CTRL) begin
                rdata_reg[2:0] <= ctrl_reg;
            end else if (avs_address_i == `FES_OFF_PORT_OUT) begin
                rdata_reg[5:0] <= port_out_reg;
            end else if (avs_address_i == `FES_OFF_PORT_CFG) begin
                rdata_reg[5:0] <= port_cfg_reg;
            end else if (avs_address_i == `FES_OFF_PORT_IN) begin
                rdata_reg[3:0] <= pins_now;
                rdata_reg[`FES_PORT_IN_CHG_BIT] <= chg_flag_reg;
            end else if (avs_address_i == `FES_OFF_STATUS) begin
                rdata_reg[PC_W-1:0] <= pc_reg;
                rdata_reg[15:12] <= phase_reg;
                rdata_reg[16 +: IW] <= ir_reg;
                rdata_reg[`FES_STAT_VALID_BIT] <= ir_valid_reg;
            end else if (avs_address_i == `FES_OFF_PMEM_ADDR) begin
                rdata_reg[PC_W-1:0] <= pmem_addr_reg;
            end
        end else begin
            wait_reg <= 1'b1;
        end
    end

    // Outputs straight from flip-flops.
    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign exec_instr_o = ir_reg;
    assign exec_valid_o = ir_valid_reg;
    assign operand_o = operand_reg;
    assign phase_o = phase_reg;
    assign dmem_rd_o = dmem_rd_reg;
    assign dmem_wr_o = dmem_wr_reg;
    assign dmem_addr_o = dmem_addr_reg;
    assign dmem_wdata_o = dmem_wdata_reg;
    assign port_pin_out_o = pin_out_reg;
    assign port_pin_oe_o = pin_oe_reg;
    assign pull_up_en_o = pull_reg;
    assign timer_clock_input_o = tclk_reg;
    assign quarter_osc_output_o = quarter_reg;
    assign wake_o = wake_reg;
endmodule

// *** sim/fes_dmem_model.sv ***
// Behavioural data register file facing the sequencer.
module fes_dmem_model (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [4:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Byte store, seeded with a pattern the bench mirrors.
    logic [7:0] mem [32];
    // Last byte handed out, used to show a released bus.
    logic [7:0] last_q = 8'h00;
    initial begin
        for (int i = 0; i < 32; i++) begin
            mem[i] = 8'h40 + 8'(i);
        end
    end
    // Writes land on the strobe edge; reads remember the byte.
    always @(posedge clk_i) begin
        if (wr_i) begin
            mem[addr_i] <= wdata_i;
        end
        if (rd_i) begin
            last_q <= mem[addr_i];
        end
    end
    // Outside a read the bus carries the inverse of the last byte.
    assign rdata_o = rd_i ? mem[addr_i] : ~last_q;
endmodule

// *** sim/fes_seq_assertions.sv ***
// Concurrent checks on the sequencer's ports, bound into its top.
module fes_seq_assertions import fes_seq_pkg::*; #(
    parameter int IW = 12
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic jump_i,
    input wire logic dest_write_i,
    input wire logic [7:0] result_i,
    input wire logic [7:0] dmem_rdata_i,
    input wire logic [IW-1:0] exec_instr_o,
    input wire logic exec_valid_o,
    input wire logic [7:0] operand_o,
    input wire logic [3:0] phase_o,
    input wire logic dmem_rd_o,
    input wire logic dmem_wr_o,
    input wire logic [7:0] dmem_wdata_o,
    input wire logic [2:0] port_pin_in_i,
    input wire logic port_pin_three_i,
    input wire logic [3:0] pull_up_en_o,
    input wire logic timer_clock_input_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pin three low may be a master clear, so checks rest then too.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i || !port_pin_three_i);
    // The phases that follow phase one, in order.
    sequence s_tail;
        phase_o == FES_PH_TWO ##1 phase_o == FES_PH_THREE
            ##1 phase_o == FES_PH_FOUR;
    endsequence
    // An empty slot of four clocks, then a valid one.
    sequence s_bubble;
        !exec_valid_o [*4] ##1 exec_valid_o;
    endsequence
    a_phase_rotates: assert property (
        phase_o == FES_PH_ONE |=> s_tail ##1 phase_o == FES_PH_ONE)
        else $error("phase order broken");
    // A word loaded at the phase one edge first shows during phase two.
    a_ir_holds: assert property (
        phase_o != FES_PH_TWO |-> $stable(exec_instr_o)
            && $stable(exec_valid_o))
        else $error("instruction changed off phase one");
    a_read_phase: assert property (
        dmem_rd_o == (phase_o == FES_PH_TWO && exec_valid_o))
        else $error("read strobe misplaced");
    a_write_phase: assert property (
        dmem_wr_o == (phase_o == FES_PH_FOUR && exec_valid_o
            && $past(dest_write_i)))
        else $error("write strobe misplaced");
    a_write_data: assert property (
        dmem_wr_o |-> dmem_wdata_o == $past(result_i))
        else $error("write data wrong");
    a_operand_taken: assert property (
        phase_o == FES_PH_TWO && exec_valid_o
            |=> operand_o == $past(dmem_rdata_i))
        else $error("operand not captured");
    a_jump_flush: assert property (
        phase_o == FES_PH_FOUR && exec_valid_o && jump_i |=> ##1 s_bubble)
        else $error("jump did not flush one slot");
    a_steady_flow: assert property (
        phase_o == FES_PH_FOUR && exec_valid_o && !jump_i
            |-> ##2 exec_valid_o)
        else $error("bubble without jump");
    a_reset_bubble: assert property (
        $fell(reset_i) |=> s_bubble)
        else $error("first slot after reset not empty");
    a_timer_copy: assert property (
        timer_clock_input_o |-> $past(port_pin_in_i[2]))
        else $error("timer input without pin level");
    a_pin_two_plain: assert property (
        !pull_up_en_o[2])
        else $error("pull-up on pin two");
endmodule

bind fes_seq fes_seq_assertions #(.IW(IW)) u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .jump_i(jump_i),
    .dest_write_i(dest_write_i), .result_i(result_i),
    .dmem_rdata_i(dmem_rdata_i), .exec_instr_o(exec_instr_o),
    .exec_valid_o(exec_valid_o), .operand_o(operand_o),
    .phase_o(phase_o), .dmem_rd_o(dmem_rd_o), .dmem_wr_o(dmem_wr_o),
    .dmem_wdata_o(dmem_wdata_o), .port_pin_in_i(port_pin_in_i),
    .port_pin_three_i(port_pin_three_i), .pull_up_en_o(pull_up_en_o),
    .timer_clock_input_o(timer_clock_input_o)
);

// *** sim/fes_seq_tb.sv ***
// Self-checking bench for the fetch and execute sequencer.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // Calibration word served from the top program word.
    localparam logic [11:0] CAL = 12'h5a5;
    logic clk_i, reset_i, avs_read_i, avs_write_i, jump_i, dest_write_i;
    logic port_pin_three_i, comparator_output_i, wake_o;
    logic [2:0] avs_address_i, port_pin_in_i, port_pin_out_o, port_pin_oe_o;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [3:0] avs_byteenable_i, phase_o, pull_up_en_o;
    logic [8:0] jump_target_i;
    logic [7:0] result_i, dmem_rdata_i, operand_o, dmem_wdata_o;
    logic [11:0] exec_instr_o;
    logic [4:0] dmem_addr_o;
    logic avs_waitrequest_o, exec_valid_o, dmem_rd_o, dmem_wr_o;
    logic timer_clock_input_o, quarter_osc_output_o;
    // Bench copy of the data register file.
    logic [7:0] exm [32];
    int mismatches = 0;
    int n_tests = 0;

    fes_seq #(.CAL_VALUE(CAL)) uut (
        .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .jump_i(jump_i),
        .jump_target_i(jump_target_i), .dest_write_i(dest_write_i),
        .result_i(result_i), .dmem_rdata_i(dmem_rdata_i),
        .exec_instr_o(exec_instr_o), .exec_valid_o(exec_valid_o),
        .operand_o(operand_o), .phase_o(phase_o), .dmem_rd_o(dmem_rd_o),
        .dmem_wr_o(dmem_wr_o), .dmem_addr_o(dmem_addr_o),
        .dmem_wdata_o(dmem_wdata_o), .port_pin_in_i(port_pin_in_i),
        .port_pin_out_o(port_pin_out_o), .port_pin_oe_o(port_pin_oe_o),
        .port_pin_three_i(port_pin_three_i), .pull_up_en_o(pull_up_en_o),
        .comparator_output_i(comparator_output_i),
        .timer_clock_input_o(timer_clock_input_o),
        .quarter_osc_output_o(quarter_osc_output_o), .wake_o(wake_o)
    );
    fes_dmem_model dm (
        .clk_i(clk_i), .rd_i(dmem_rd_o), .wr_i(dmem_wr_o),
        .addr_i(dmem_addr_o), .wdata_i(dmem_wdata_o),
        .rdata_o(dmem_rdata_i)
    );

    // Free-running 4 ns clock.
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Compare one result and count it.
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
            input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One bus access, held until waitrequest is seen low.
    task automatic bus(input logic w, input logic [2:0] a,
            input logic [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Wait for the edge that closes the given phase.
    task automatic at_phase(input logic [3:0] p);
        do @(posedge clk_i); while (phase_o !== p);
    endtask

    // Let registered outputs follow a change.
    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask

    // Load one program word through the address and data registers.
    task automatic pw(input logic [8:0] a, input logic [11:0] d);
        bus(1'b1, 3'h5, 32'(a));
        bus(1'b1, 3'h6, 32'(d));
    endtask

    // Follow one slot: word, operand and an even-word result write.
    task automatic step(input logic v, input logic [11:0] ins);
        logic [4:0] a;
        logic wr;
        a = ins[4:0];
        wr = v && !ins[0];
        at_phase(4'b0010);
        cmp(exec_valid_o, 32'(v), "slot valid");
        if (v) cmp(exec_instr_o, 32'(ins), "word");
        dest_write_i <= wr;
        result_i <= {3'h6, a};
        @(posedge clk_i);
        if (v) cmp(operand_o, 32'(exm[a]), "operand");
        dest_write_i <= 1'b0;
        if (wr) exm[a] = {3'h6, a};
    endtask

    // Hold a jump through phase four of the current slot.
    task automatic jump(input logic [8:0] t);
        jump_i <= 1'b1;
        jump_target_i <= t;
        @(posedge clk_i);
        jump_i <= 1'b0;
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        $display("wrong value at %0t: run hung", $time);
        close_out();
    end

    initial begin
        reset_i <= 1'b1;
        {avs_read_i, avs_write_i, jump_i, dest_write_i} <= 4'h0;
        avs_address_i <= 3'h0;
        avs_writedata_i <= 32'h0;
        avs_byteenable_i <= 4'hf;
        jump_target_i <= 9'h000;
        result_i <= 8'h00;
        port_pin_in_i <= 3'b100;
        // Master clear holds the pipeline until the program is loaded.
        port_pin_three_i <= 1'b0;
        comparator_output_i <= 1'b0;
        for (int i = 0; i < 32; i++) exm[i] = 8'h40 + 8'(i);
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        // Reset values, and an unmapped place that ignores writes.
        bus(1'b1, 3'h7, 32'hffff);
        for (int i = 0; i < 8; i++) begin
            if (i < 3 || i > 5) begin
                bus(1'b0, 3'(i), 32'h0);
                cmp(q, 32'(i == 0), "register read");
            end
        end
        cmp(pull_up_en_o, 32'h8, "pull-ups at reset");
        $display("register test done");
        // Fill every word; the writes to the top word are refused.
        for (int i = 0; i < 256; i++) pw(9'(i), 12'ha00 + 12'(i));
        pw(9'h010, 12'hb10);
        pw(9'h011, 12'hb11);
        pw(9'h0ff, 12'h123);
        // Master clear restarts the pipeline at word zero.
        port_pin_three_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        port_pin_three_i <= 1'b1;
        step(1'b0, 12'h000);
        for (int i = 0; i < 3; i++) step(1'b1, 12'ha00 + 12'(i));
        jump(9'h110);
        step(1'b0, 12'h000);
        jump(9'h050);
        step(1'b1, 12'hb10);
        step(1'b1, 12'hb11);
        jump(9'h0ff);
        step(1'b0, 12'h000);
        step(1'b1, CAL);
        step(1'b1, 12'ha00);
        // The last result lands one edge later; read it after that.
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 32; i++) begin
            cmp(dm.mem[i], 32'(exm[i]), "byte");
        end
        $display("pipeline test done");
        // A reset in mid-run restarts at word zero with one empty slot.
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        step(1'b0, 12'h000);
        step(1'b1, 12'ha00);
        $display("reset test done");
        // Pin two functions, with all outputs enabled, pins zero and two high, pin one low and comparator low.
        bus(1'b1, 3'h1, 32'h3d);
        for (int f = 0; f < 4; f++) begin
            bus(1'b1, 3'h0, 32'(f * 2 + 1));
            settle();
            cmp(timer_clock_input_o, 32'(f == 1), "timer");
            if (f == 0) cmp(port_pin_out_o, 32'h5, "pins");
            cmp(port_pin_oe_o, (f == 1) ? 32'h3 : 32'h7, "oe");
            if (f == 2) cmp(port_pin_out_o[2], 32'h0, "comp");
        end
        at_phase(4'b0010);
        cmp(quarter_osc_output_o, 32'h0, "quarter low");
        at_phase(4'b1000);
        cmp(quarter_osc_output_o, 32'h1, "quarter high");
        $display("pin two test done");
        // Pull-ups, the forced clear pull-up, and wake on change.
        bus(1'b1, 3'h2, 32'h0b);
        settle();
        cmp(pull_up_en_o, 32'hb, "pull-ups");
        bus(1'b1, 3'h0, 32'h0);
        settle();
        cmp(pull_up_en_o, 32'h3, "pull-ups no clear");
        port_pin_in_i <= 3'b101;
        settle();
        cmp(wake_o, 32'h1, "wake");
        bus(1'b0, 3'h3, 32'h0);
        cmp(q, 32'h10d, "pin input");
        bus(1'b1, 3'h3, 32'h100);
        bus(1'b0, 3'h3, 32'h0);
        cmp(q, 32'h00d, "flag clear");
        $display("port test done");
        close_out();
    end
endmodule
